// >>> hw/sddc_pkg.sv
// Shared constants and types for the sigma-delta decimation and calibration block
package sddc_pkg;
    // Widths
    localparam int WORD_W = 40;
    localparam int DATA_W = 24;
    localparam int NOTCH_W = 11;
    localparam int DEC_W = 13;
    localparam int ADDR_W = 3;
    localparam int GAIN_W = 3;
    localparam int ORDER = 3;
    // Modulator sample every 128 master clocks
    localparam logic [6:0] PRE_LAST = 7'h7f;
    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_OFF = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_POS = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_NEG = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 3'h5;
    // Control register field positions
    localparam int CTRL_NOTCH_LSB = 0;
    localparam int CTRL_OP_LSB = 11;
    localparam int CTRL_GAIN_LSB = 14;
    // Values after reset, then the mid-scale and two-unity correction constants
    localparam logic [NOTCH_W-1:0] RST_NOTCH = 11'h00a;
    localparam logic [GAIN_W-1:0] RST_GAIN = 3'h0;
    localparam logic [DATA_W-1:0] RST_OFF = 24'h000000;
    localparam logic [DATA_W-1:0] RST_FS = 24'h800000;
    localparam logic [DATA_W-1:0] MID_SCALE = 24'h800000;
    localparam logic [DATA_W:0] TWO_UNITY = 25'h1000000;
    // Conversion periods per step
    localparam logic [2:0] CONV_PERIODS = 3'h3;
    localparam logic [2:0] CAL_PERIODS = 3'h3;
    localparam logic [2:0] SYS_PERIODS = 3'h4;
    localparam logic [2:0] TAIL_PERIODS = 3'h1;

    typedef enum logic [2:0] {
        OP_CONV = 3'b000,
        OP_SELF = 3'b001,
        OP_SYS_OFF = 3'b010,
        OP_SYS_POS = 3'b011,
        OP_SYS_NEG = 3'b100,
        OP_SYS_OFF_INT = 3'b101,
        OP_SYS_GAIN = 3'b110,
        OP_RSVD = 3'b111
    } sddc_op_e;

    typedef enum logic [2:0] {
        SW_EXT = 3'b000,
        SW_SHORT = 3'b001,
        SW_REF_POS = 3'b010,
        SW_REF_NEG = 3'b011,
        SW_EXT_REV = 3'b100
    } sddc_sw_e;

    typedef enum logic [1:0] {
        TGT_NONE = 2'b00,
        TGT_OFF = 2'b01,
        TGT_POS = 2'b10,
        TGT_NEG = 2'b11
    } sddc_tgt_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_CONV = 2'b10,
        ST_DONE = 2'b11
    } sddc_state_e;

    typedef struct packed {
        logic [2:0] periods;
        sddc_sw_e sw;
        sddc_tgt_e tgt;
        logic last;
    } sddc_step_s;
endpackage

// >>> hw/sddc_filt_if.sv
// Link between the sequencer and the sinc3 decimator
`timescale 1ns/1ps
interface sddc_filt_if;
    import sddc_pkg::*;
    logic sample_strobe;
    logic sample_bit;
    logic restart;
    logic [NOTCH_W-1:0] notch_code;
    logic [WORD_W-1:0] word;
    logic word_valid;
    modport ctrl (output sample_strobe, sample_bit, restart, notch_code, input word, word_valid);
    modport filt (input sample_strobe, sample_bit, restart, notch_code, output word, word_valid);
endinterface

// >>> hw/sddc_sinc3.sv
// Third-order integrator-comb decimator fed by one-bit modulator samples
`timescale 1ns/1ps
module sddc_sinc3
    import sddc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Sample and word link
    sddc_filt_if.filt f
);
    typedef struct packed {
        logic [ORDER-1:0][WORD_W-1:0] integ;
        logic [ORDER-1:0][WORD_W-1:0] dly;
        logic [DEC_W-1:0] count;
        logic [WORD_W-1:0] word;
        logic valid;
    } sddc_filt_s;

    sddc_filt_s s;
    sddc_filt_s next_s;
    logic [WORD_W-1:0] acc;
    logic [DEC_W-1:0] dec_last;

    // Ratio is four samples per notch code step
    assign dec_last = {f.notch_code, 2'b00} - 13'h1;

    // Integrators run per sample, combs once per decimated word
    always_comb begin
        next_s = s;
        acc = '0;
        next_s.valid = 1'b0;
        if (f.restart) begin
            next_s = '0;
        end else if (f.sample_strobe) begin
            acc = f.sample_bit ? {{(WORD_W-1){1'b0}}, 1'b1} : {WORD_W{1'b1}}; // RQ2
            for (int i = 0; i < ORDER; i++) begin
                next_s.integ[i] = s.integ[i] + acc; // RQ6
                acc = next_s.integ[i];
            end
            // Comparing with >= keeps a shrinking code from running away
            if (s.count >= dec_last) begin
                next_s.count = '0; // RQ3
                for (int i = 0; i < ORDER; i++) begin
                    next_s.dly[i] = acc; // RQ6
                    acc = acc - s.dly[i];
                end
                next_s.word = acc;
                next_s.valid = 1'b1; // RQ4
            end else begin
                next_s.count = s.count + 13'h1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign f.word = s.word;
    assign f.word_valid = s.valid;

    // Each sample enters as plus or minus one
    sample_expand_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ2
        (f.sample_strobe && !f.restart) |=> ((s.integ[0] - $past(s.integ[0])) == 40'h1
        || (s.integ[0] - $past(s.integ[0])) == 40'hffffffffff))
        else $error("sample not expanded to plus or minus one");

    // A word leaves after exactly four times the code in samples
    decim_ratio_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ3
        s.valid |-> ($past(s.count) == ({f.notch_code, 2'b00} - 13'h1)))
        else $error("decimation ratio differs from four times notch code");
endmodule

// >>> hw/sddc_ctrl.sv
// Conversion and calibration sequencer with register port and sinc3 decimator
// Overview of operation
// (RQ1) Modulator bit sampled every 128 clocks
// (RQ2) Each sample widened to 40-bit word
// (RQ3) Notch equals clock over 512 times code
// (RQ4) One output word per notch period
// (RQ5) Host keeps notch code within 10..2047
// (RQ6) Decimator is fixed third-order integrator-comb
// (RQ7) Step input settles within three-four periods
// (RQ8) Three-bit field selects one of modes
// (RQ9) Every calibration ends with result valid low
// (RQ10) Conversion waits three periods before result valid
// (RQ11) Conversion corrects data, coefficients stay unchanged
// (RQ12) Self cal shorts inputs, offset after three
// (RQ13) Then reference applied, positive after three
// (RQ14) Then reference reversed, negative after three
// (RQ15) Three more periods, then result valid
// (RQ16) Host uses self cal at gain one
// (RQ17) System offset stored, valid after four
// (RQ18) System positive stored, valid after four
// (RQ19) Host settles input before system calibration
// (RQ20) Host writes unity coefficients for raw data
// (RQ21) Host runs offset before gain calibrations
// (RQ22) Host recalibrates after gain or notch change
// (RQ23) System negative stored, valid after four
// (RQ24) Host never writes the reserved mode
// (RQ25) Mode write restarts period counting from zero
`timescale 1ns/1ps
module sddc_ctrl
    import sddc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rd_data_out,
    // Modulator and analog switches
    input wire logic mod_bit_in,
    output logic [2:0] input_select_out,
    output logic [GAIN_W-1:0] input_gain_amplifier_out,
    // Status
    output logic result_valid_n_out
);
    typedef struct packed {
        logic [2:0] sync;
        logic mod_level;
        logic [6:0] pre;
        logic strobe;
        logic samp;
        logic restart;
        logic [NOTCH_W-1:0] notch_code;
        sddc_op_e operation_select;
        logic [GAIN_W-1:0] gain;
        logic [DATA_W-1:0] off_coef;
        logic [DATA_W-1:0] pos_coef;
        logic [DATA_W-1:0] neg_coef;
        logic [DATA_W-1:0] data_out;
        sddc_state_e state;
        logic [1:0] step;
        logic [2:0] periods;
        sddc_sw_e sw;
        logic result_valid_n;
        logic [DATA_W-1:0] rdata;
        logic [4:0] wcnt;
    } sddc_ctrl_s;

    // Power-up runs conversion mode with unity coefficients
    localparam sddc_ctrl_s RESET_S = '{
        sync: 3'h0, mod_level: 1'b0, pre: 7'h00, strobe: 1'b0, samp: 1'b0, restart: 1'b1,
        notch_code: RST_NOTCH, operation_select: OP_CONV, gain: RST_GAIN,
        off_coef: RST_OFF, pos_coef: RST_FS, neg_coef: RST_FS, data_out: RST_OFF,
        state: ST_RUN, step: 2'h0, periods: 3'h0, sw: SW_EXT, result_valid_n: 1'b1,
        rdata: 24'h000000, wcnt: 5'h00};

    sddc_ctrl_s s;
    sddc_ctrl_s next_s;
    sddc_step_s cur;
    sddc_step_s nxt;
    sddc_step_s first;
    logic ctrl_wr;
    logic signed [DATA_W-1:0] dev;
    logic signed [DATA_W:0] cdiff;
    logic signed [DATA_W:0] cmag;
    logic signed [2*DATA_W+1:0] prod;
    logic signed [DATA_W+2:0] scaled;
    logic [DATA_W-1:0] sat;
    logic [DATA_W-1:0] corr;
    logic [DATA_W-1:0] gcoef;
    logic [4:0] wcnt;

    sddc_filt_if fbus();

    sddc_sinc3 i_sddc_sinc3 (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .f(fbus.filt)
    );

    // Step table: switch setting, length and destination of each phase
    function automatic sddc_step_s step_info(input sddc_op_e op, input logic [1:0] idx);
        sddc_step_s r;
        r = '{periods: CAL_PERIODS, sw: SW_EXT, tgt: TGT_NONE, last: 1'b0};
        case (op) // RQ8
            OP_CONV: begin
                r.periods = CONV_PERIODS; // RQ10
                r.last = 1'b1;
            end
            OP_SELF, OP_SYS_OFF_INT: begin
                case (idx)
                    2'h0: begin
                        r.sw = (op == OP_SELF) ? SW_SHORT : SW_EXT; // RQ12
                        r.tgt = TGT_OFF;
                    end
                    2'h1: begin
                        r.sw = SW_REF_POS; // RQ13
                        r.tgt = TGT_POS;
                    end
                    2'h2: begin
                        r.sw = SW_REF_NEG; // RQ14
                        r.tgt = TGT_NEG;
                    end
                    default: begin
                        r.last = 1'b1; // RQ15
                    end
                endcase
            end
            OP_SYS_OFF: begin
                r.periods = SYS_PERIODS; // RQ17
                r.tgt = TGT_OFF;
                r.last = 1'b1;
            end
            OP_SYS_POS: begin
                r.periods = SYS_PERIODS; // RQ18
                r.tgt = TGT_POS;
                r.last = 1'b1;
            end
            OP_SYS_NEG: begin
                r.periods = SYS_PERIODS; // RQ23
                r.tgt = TGT_NEG;
                r.last = 1'b1;
            end
            OP_SYS_GAIN: begin
                case (idx)
                    2'h0: begin
                        r.tgt = TGT_NEG;
                    end
                    2'h1: begin
                        r.sw = SW_EXT_REV;
                        r.tgt = TGT_POS;
                    end
                    default: begin
                        r.periods = TAIL_PERIODS;
                        r.last = 1'b1;
                    end
                endcase
            end
            default: begin
                r.last = 1'b1;
            end
        endcase
        return r;
    endfunction

    // Correction: subtract offset, then scale by the slope of that side
    assign dev = fbus.word[WORD_W-1 -: DATA_W];
    assign cdiff = {dev[DATA_W-1], dev} - {s.off_coef[DATA_W-1], s.off_coef}; // RQ11
    assign cmag = cdiff[DATA_W] ? -cdiff : cdiff;
    assign prod = cdiff * $signed({1'b0, cdiff[DATA_W] ? s.neg_coef : s.pos_coef});
    assign scaled = prod[2*DATA_W+1:DATA_W-1];
    assign sat = (scaled > 27'sh07fffff) ? 24'h7fffff :
                 (scaled < -27'sh0800000) ? 24'h800000 : scaled[DATA_W-1:0];
    assign corr = sat ^ MID_SCALE;
    // First-order reciprocal keeps a divider out of the datapath
    assign gcoef = (cmag == 25'sh0) ? 24'hffffff : 24'(TWO_UNITY - cmag);
    assign ctrl_wr = wr_in && (addr_in == ADDR_CTRL);
    assign cur = step_info(s.operation_select, s.step);
    assign nxt = step_info(s.operation_select, 2'(s.step + 2'h1));
    // First phase of the mode being written, so the switches move with the write
    assign first = step_info(sddc_op_e'(wr_data_in[CTRL_OP_LSB +: 3]), 2'h0);

    // Next-state logic for pins, register port and sequencer
    always_comb begin
        next_s = s;
        next_s.sync = {s.sync[1:0], mod_bit_in};
        // Accept a new level only once the last two stages agree
        if (s.sync[1] == s.sync[2]) begin
            next_s.mod_level = s.sync[2];
        end
        next_s.pre = s.pre + 7'h01;
        next_s.strobe = (s.pre == PRE_LAST); // RQ1
        next_s.samp = s.mod_level;
        // Words seen since the last restart, saturating, for the checks below
        if (s.restart) begin
            next_s.wcnt = 5'h00;
        end else if (fbus.word_valid && s.wcnt != 5'h1f) begin
            next_s.wcnt = 5'(s.wcnt + 5'h01);
        end
        next_s.restart = 1'b0;
        next_s.rdata = '0;
        if (rd_in) begin
            case (addr_in)
                ADDR_CTRL: next_s.rdata = {7'h00, s.gain, s.operation_select, s.notch_code};
                ADDR_OFF: next_s.rdata = s.off_coef;
                ADDR_POS: next_s.rdata = s.pos_coef;
                ADDR_NEG: next_s.rdata = s.neg_coef;
                ADDR_DATA: next_s.rdata = s.data_out;
                ADDR_STAT: next_s.rdata = {16'h0000, s.periods, s.step, s.state, s.result_valid_n};
                default: next_s.rdata = '0;
            endcase
            // Reading the result releases the flag; a new result below wins
            if (addr_in == ADDR_DATA) begin
                next_s.result_valid_n = 1'b1;
            end
        end
        if (wr_in) begin
            case (addr_in)
                ADDR_OFF: next_s.off_coef = wr_data_in;
                ADDR_POS: next_s.pos_coef = wr_data_in;
                ADDR_NEG: next_s.neg_coef = wr_data_in;
                default: next_s.off_coef = s.off_coef;
            endcase
        end
        if (ctrl_wr) begin
            next_s.notch_code = wr_data_in[CTRL_NOTCH_LSB +: NOTCH_W];
            next_s.operation_select = sddc_op_e'(wr_data_in[CTRL_OP_LSB +: 3]);
            next_s.gain = wr_data_in[CTRL_GAIN_LSB +: GAIN_W];
            next_s.restart = 1'b1; // RQ25
            next_s.step = 2'h0;
            next_s.periods = 3'h0;
            next_s.result_valid_n = 1'b1;
            next_s.sw = first.sw;
            // Reserved code has no sequence, so the block parks
            next_s.state = (next_s.operation_select == OP_RSVD) ? ST_IDLE : ST_RUN;
        end else if (fbus.word_valid && !s.restart) begin
            case (s.state)
                ST_RUN: begin
                    if (3'(s.periods + 3'h1) == cur.periods) begin
                        case (cur.tgt)
                            TGT_OFF: next_s.off_coef = dev; // RQ12
                            TGT_POS: next_s.pos_coef = gcoef; // RQ13
                            TGT_NEG: next_s.neg_coef = gcoef; // RQ14
                            default: next_s.off_coef = next_s.off_coef;
                        endcase
                        next_s.periods = 3'h0;
                        if (cur.last) begin
                            next_s.data_out = corr;
                            next_s.result_valid_n = 1'b0; // RQ9
                            next_s.sw = SW_EXT;
                            next_s.state = (s.operation_select == OP_CONV) ? ST_CONV : ST_DONE; // RQ7
                        end else begin
                            next_s.step = 2'(s.step + 2'h1);
                            next_s.sw = nxt.sw;
                        end
                    end else begin
                        next_s.periods = 3'(s.periods + 3'h1);
                    end
                end
                ST_CONV: begin
                    next_s.data_out = corr; // RQ11
                    next_s.result_valid_n = 1'b0; // RQ4
                end
                default: begin
                    next_s.state = s.state;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= RESET_S;
        end else begin
            s <= next_s;
        end
    end

    assign fbus.sample_strobe = s.strobe;
    assign fbus.sample_bit = s.samp;
    assign fbus.restart = s.restart;
    assign fbus.notch_code = s.notch_code;
    assign rd_data_out = s.rdata;
    assign input_select_out = s.sw;
    assign input_gain_amplifier_out = s.gain;
    assign result_valid_n_out = s.result_valid_n;

    // Helper: word count kept in the state struct
    assign wcnt = s.wcnt;

    mod_rate_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ1
        s.strobe |-> ##128 s.strobe)
        else $error("modulator sample spacing is not 128 clocks");

    conv_wait_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ10
        ($fell(s.result_valid_n) && $past(s.state) == ST_RUN && s.operation_select == OP_CONV)
        |-> wcnt == 5'h03)
        else $error("conversion result not after three periods");

    sys_wait_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ17
        ($fell(s.result_valid_n) && $past(s.state) == ST_RUN
        && s.operation_select inside {OP_SYS_OFF, OP_SYS_POS, OP_SYS_NEG}) |-> wcnt == 5'h04)
        else $error("system calibration not done after four periods");

    self_done_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ15
        ($fell(s.result_valid_n) && s.operation_select == OP_SELF) |-> wcnt == 5'h0c)
        else $error("self calibration not done after twelve periods");

    self_short_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ12
        (!s.restart && s.state == ST_RUN && s.operation_select == OP_SELF && wcnt < 5'h03) |-> s.sw == SW_SHORT)
        else $error("inputs not shorted during offset step");

    self_pos_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ13
        (!s.restart && s.state == ST_RUN && s.operation_select == OP_SELF && wcnt inside {[5'h03:5'h05]})
        |-> s.sw == SW_REF_POS)
        else $error("reference not applied during positive step");

    self_neg_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ14
        (!s.restart && s.state == ST_RUN && s.operation_select == OP_SELF && wcnt inside {[5'h06:5'h08]})
        |-> s.sw == SW_REF_NEG)
        else $error("reference not reversed during negative step");

    coef_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ11
        (s.operation_select == OP_CONV && !wr_in)
        |=> ($stable(s.off_coef) && $stable(s.pos_coef) && $stable(s.neg_coef)))
        else $error("coefficient changed in conversion mode");

    mode_restart_a: assert property (@(posedge clk_in) disable iff (rst_in) // RQ25
        ctrl_wr |=> (s.restart && s.step == 2'h0 && s.periods == 3'h0) ##1 (wcnt == 5'h00))
        else $error("mode write did not restart period counting");
endmodule

// >>> testbench/sddc_mod_model.sv
// Behavioural one-bit modulator whose ones density follows the analog switch setting
`timescale 1ns/1ps
module sddc_mod_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Switch setting and external level in eighths of full density
    input wire logic [2:0] input_select_in,
    input wire logic [3:0] level_in,
    // Modulator stream
    output logic mod_bit_out
);
    logic [9:0] count;
    logic [3:0] dens;

    // References sit off centre so that each calibration step sees a different input
    always_comb begin
        case (input_select_in)
            3'h1: dens = 4'h4;
            3'h2: dens = 4'h6;
            3'h3: dens = 4'h2;
            3'h4: dens = 4'h8 - level_in;
            default: dens = level_in;
        endcase
    end

    // A new bit every 128 clocks; the pattern repeats over eight bits
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= 10'h000;
            mod_bit_out <= 1'b0;
        end else begin
            count <= count + 10'h001;
            if (count[6:0] == 7'h7f) begin
                mod_bit_out <= ({1'b0, count[9:7]} < dens);
            end
        end
    end
endmodule

// >>> testbench/test_sddc_ctrl.sv
// Self-checking bench for the conversion and calibration sequencer
`timescale 1ns/1ps
module test_sddc_ctrl;
    import sddc_pkg::*;
    localparam int PER = 512 * 10;
    localparam int SLACK = 300;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [ADDR_W-1:0] addr_in = 3'h0;
    logic [DATA_W-1:0] wr_data_in = 24'h000000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [DATA_W-1:0] rd_data_out;
    logic mod_bit;
    logic [2:0] input_select_out;
    logic [GAIN_W-1:0] input_gain_amplifier_out;
    logic result_valid_n_out;
    logic [3:0] level = 4'h4;
    logic [2:0] g;
    logic [DATA_W-1:0] v;
    int num_errors = 0;
    int num_checks = 0;
    int n;

    sddc_ctrl i_sddc_ctrl (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .mod_bit_in(mod_bit),
        .input_select_out(input_select_out), .input_gain_amplifier_out(input_gain_amplifier_out),
        .result_valid_n_out(result_valid_n_out)
    );
    sddc_mod_model i_sddc_mod_model (
        .clk_in(clk_in), .rst_in(rst_in), .input_select_in(input_select_out),
        .level_in(level), .mod_bit_out(mod_bit)
    );

    // Master clock, 50 ns period
    always #25 clk_in = ~clk_in;

    // Comparison and bus helpers
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic win(input int c, input int lo, input int hi);
        check({23'h0, c > lo && c < hi}, 24'h000001);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken just after that edge
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rd_data_out;
    endtask
    // Bounded wait for the active-low ready flag, returning the cycles spent
    task automatic wait_ready(input int lim, output int c);
        c = 0;
        while (result_valid_n_out !== 1'b0 && c < lim) begin
            @(posedge clk_in);
            #1 c++;
        end
    endtask
    function automatic logic [DATA_W-1:0] ctrl(input logic [2:0] op, input logic [2:0] g);
        return {7'h00, g, op, 11'h00a};
    endfunction
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog sized for about eighteen conversion periods plus margin
    initial begin
        #(100000 * 50);
        num_errors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        cyc(12);
        rst_in <= 1'b0;
        // Reset values, then an unmapped place that must ignore writes
        rd(ADDR_CTRL, v);
        check(v, 24'h00000a);
        rd(ADDR_OFF, v);
        check(v, 24'h000000);
        rd(ADDR_POS, v);
        check(v, 24'h800000);
        rd(ADDR_NEG, v);
        check(v, 24'h800000);
        wr(3'h6, 24'h123456);
        rd(3'h6, v);
        check(v, 24'h000000);
        $display("test registers done");
        // Every usable mode code, in code order from conversion: restart, state, first switch step, gain
        for (int op = 0; op < 7; op++) begin
            g = (op == 1 || op == 5) ? 3'h0 : op[2:0];
            wr(ADDR_CTRL, ctrl(op[2:0], g));
            cyc(4);
            check({21'h0, input_gain_amplifier_out}, {21'h0, g});
            rd(ADDR_STAT, v);
            check({21'h0, v[2:0]}, {21'h0, 2'h1, 1'b1});
            check({21'h0, input_select_out}, {23'h0, op == 1});
        end
        $display("test modes done");
        // Conversion with unity coefficients, restarted halfway through the wait
        wr(ADDR_OFF, 24'h000000);
        wr(ADDR_POS, 24'h800000);
        wr(ADDR_NEG, 24'h800000);
        wr(ADDR_CTRL, ctrl(3'h0, 3'h0));
        cyc(PER * 3 / 2);
        check({23'h0, result_valid_n_out}, 24'h000001);
        wr(ADDR_CTRL, ctrl(3'h0, 3'h0));
        wait_ready(4 * PER, n);
        win(n, 3 * PER - SLACK, 3 * PER + SLACK);
        rd(ADDR_DATA, v);
        check(v, MID_SCALE);
        check({23'h0, result_valid_n_out}, 24'h000001);
        wait_ready(2 * PER, n);
        win(n, PER - SLACK, PER + SLACK);
        rd(ADDR_OFF, v);
        check(v, 24'h000000);
        rd(ADDR_POS, v);
        check(v, 24'h800000);
        rd(ADDR_NEG, v);
        check(v, 24'h800000);
        $display("test conversion done");
        // Self calibration at gain one; switch steps are sampled mid-period
        wr(ADDR_CTRL, ctrl(3'h1, 3'h0));
        cyc(PER / 2);
        for (int k = 0; k < 12; k++) begin
            check({21'h0, input_select_out}, {22'h0, k < 9 ? 2'(k / 3 + 1) : 2'h0});
            if (k < 11) begin
                cyc(PER);
            end
        end
        check({23'h0, result_valid_n_out}, 24'h000001);
        wait_ready(PER, n);
        win(n, PER / 2 - SLACK, PER / 2 + SLACK);
        rd(ADDR_STAT, v);
        check({21'h0, v[2:0]}, {21'h0, 2'h3, 1'b0});
        // Shorted inputs read mid-scale; reference steps deviate by at most one unit
        rd(ADDR_OFF, v);
        check(v, 24'h000000);
        rd(ADDR_POS, v);
        check(v, 24'hffffff);
        rd(ADDR_NEG, v);
        check(v, 24'hffffff);
        $display("test self calibration done");
        wrap_up();
    end
endmodule
